// File: shared/rx_ctrl_pkg.sv
// Purpose: constants and types for the receiver general control bank
// Assumes: 12-bit register address, 8-bit register data
// Notes:   per-link parameter bytes arrive from the per-link bank
package rx_ctrl_pkg;

    // ------------------------------------------------------------
    // register map
    // ------------------------------------------------------------
    localparam logic [11:0] ADDR_TERMINATION_TUNE_A = 12'h2b1;
    localparam logic [11:0] ADDR_TERMINATION_TUNE_B = 12'h2b2;
    localparam logic [11:0] ADDR_RECEIVER_GEN_CTRL  = 12'h300;
    localparam logic [11:0] ADDR_PAGED_LO           = 12'h401;
    localparam logic [11:0] ADDR_PAGED_HI           = 12'h47e;
    localparam logic [11:0] ADDR_CHECKSUM_STORE     = 12'h40e;

    // ------------------------------------------------------------
    // reset values
    // ------------------------------------------------------------
    localparam logic [7:0] RST_TERMINATION_TUNE_A = 8'hc3;
    localparam logic [7:0] RST_TERMINATION_TUNE_B = 8'h93;
    localparam logic [7:0] RST_RECEIVER_GEN_CTRL  = 8'h00;
    localparam logic [7:0] RST_CHECKSUM           = 8'h00;

    // ------------------------------------------------------------
    // control register fields
    // ------------------------------------------------------------
    localparam int         POS_CHECKSUM_MODE = 6;
    localparam int         POS_LINK_MODE     = 3;
    localparam int         POS_LINK_PAGE     = 2;
    localparam int         POS_LINK_EN_LO    = 0;
    localparam logic [7:0] CTRL_WRITE_MASK   = 8'h4f;

    // packed link parameter bytes, index 0 at the lowest address
    localparam int NUM_CFG_BYTES = 13;
    localparam int NUM_LINKS     = 2;

    typedef logic [NUM_CFG_BYTES-1:0][7:0] cfg_bytes_t;
    typedef logic [NUM_LINKS-1:0][7:0]     link_bytes_t;

    // host side of the serial register port
    typedef struct packed {
        logic        wr;
        logic        rd;
        logic [11:0] addr;
        logic [7:0]  wdata;
    } reg_req_t;

endpackage

// File: hw/rx_general_control.sv
// Purpose: termination tuning and receiver general control registers
// Assumes: register requests already deserialised, on i_mclk
// Notes:   read data appears one clock after the read strobe
`timescale 1ns/1ps
module rx_general_control (
    // clock and reset
    input  wire logic                      i_mclk,
    input  wire logic                      i_rst_n,
    // serial register port
    input  wire rx_ctrl_pkg::reg_req_t     i_req,
    output logic [7:0]                     o_rdata,
    output logic                           o_rvalid,
    // per-link parameter bytes
    input  wire rx_ctrl_pkg::cfg_bytes_t   i_link_cfg [2],
    // control outputs
    output logic [1:0]                     o_link_active,
    output logic                           o_dual_link,
    output logic                           o_page_link1,
    output rx_ctrl_pkg::link_bytes_t       o_computed_checksum_store,
    output logic [7:0]                     o_termination_tune_a,
    output logic [7:0]                     o_termination_tune_b
);
    import rx_ctrl_pkg::*;

    typedef struct packed {
        logic [7:0]  tune_a;
        logic [7:0]  tune_b;
        logic [7:0]  ctrl;
        link_bytes_t cks;
        logic [7:0]  rdata;
        logic        rvalid;
    } state_t;

    state_t      s;
    state_t      next_s;
    link_bytes_t sum_fields;
    link_bytes_t sum_packed;

    // --------------------------------------------------------------
    // checksum helpers
    // --------------------------------------------------------------
    // field-wise sum; reserved bits of each byte do not contribute
    function automatic logic [7:0] field_sum(input cfg_bytes_t b);
        logic [7:0] acc;
        acc = b[0];                                  // device id
        acc = acc + {4'h0, b[1][3:0]} + {4'h0, b[1][7:4]};
        acc = acc + {3'h0, b[2][4:0]} + {7'h0, b[2][5]}
                  + {7'h0, b[2][6]};
        acc = acc + {3'h0, b[3][4:0]} + {7'h0, b[3][7]};
        acc = acc + b[4] + {3'h0, b[5][4:0]} + b[6];
        acc = acc + {3'h0, b[7][4:0]} + {6'h0, b[7][7:6]};
        acc = acc + {3'h0, b[8][4:0]} + {5'h0, b[8][7:5]};
        acc = acc + {3'h0, b[9][4:0]} + {5'h0, b[9][7:5]};
        acc = acc + {3'h0, b[10][4:0]} + {7'h0, b[10][7]};
        return acc;
    endfunction

    // whole-byte sum, wraps at 256 by the 8-bit accumulator
    function automatic logic [7:0] packed_sum(input cfg_bytes_t b);
        logic [7:0] acc;
        acc = 8'h00;
        for (int i = 0; i < NUM_CFG_BYTES; i++) begin
            acc = acc + b[i];
        end
        return acc;
    endfunction

    // --------------------------------------------------------------
    // per-link sums
    // --------------------------------------------------------------
    for (genvar l = 0; l < NUM_LINKS; l++) begin : g_sum
        assign sum_fields[l] = field_sum(i_link_cfg[l]);
        assign sum_packed[l] = packed_sum(i_link_cfg[l]);
    end

    // --------------------------------------------------------------
    // next state
    // --------------------------------------------------------------
    // reads answer zero off the map so software never sees stale data
    always_comb begin
        logic [7:0] page_cks;
        page_cks = s.ctrl[POS_LINK_PAGE] ? s.cks[1] : s.cks[0];
        next_s = s;
        for (int l = 0; l < NUM_LINKS; l++) begin
            next_s.cks[l] = s.ctrl[POS_CHECKSUM_MODE]
                          ? sum_packed[l] : sum_fields[l];
        end
        if (i_req.wr) begin
            case (i_req.addr)
                ADDR_TERMINATION_TUNE_A: next_s.tune_a = i_req.wdata;
                ADDR_TERMINATION_TUNE_B: next_s.tune_b = i_req.wdata;
                ADDR_RECEIVER_GEN_CTRL:
                    next_s.ctrl = i_req.wdata & CTRL_WRITE_MASK;
                default: ;
            endcase
        end
        next_s.rvalid = i_req.rd;
        next_s.rdata  = 8'h00;
        if (i_req.rd) begin
            case (i_req.addr)
                ADDR_TERMINATION_TUNE_A: next_s.rdata = s.tune_a;
                ADDR_TERMINATION_TUNE_B: next_s.rdata = s.tune_b;
                ADDR_RECEIVER_GEN_CTRL:  next_s.rdata = s.ctrl;
                ADDR_CHECKSUM_STORE:     next_s.rdata = page_cks;
                default:                 next_s.rdata = 8'h00;
            endcase
        end
    end

    // --------------------------------------------------------------
    // state register
    // --------------------------------------------------------------
    always_ff @(posedge i_mclk) begin
        if (!i_rst_n) begin
            s.tune_a <= RST_TERMINATION_TUNE_A;
            s.tune_b <= RST_TERMINATION_TUNE_B;
            s.ctrl   <= RST_RECEIVER_GEN_CTRL;
            s.cks    <= {NUM_LINKS{RST_CHECKSUM}};
            s.rdata  <= 8'h00;
            s.rvalid <= 1'b0;
        end else begin
            s <= next_s;
        end
    end

    // outputs straight from the state register
    // links run straight from the enable bits; the host owns sequencing
    assign o_link_active = s.ctrl[POS_LINK_EN_LO +: 2];
    assign o_dual_link   = s.ctrl[POS_LINK_MODE];
    assign o_page_link1  = s.ctrl[POS_LINK_PAGE];
    assign o_computed_checksum_store = s.cks;
    assign o_termination_tune_a = s.tune_a;
    assign o_termination_tune_b = s.tune_b;
    assign o_rdata  = s.rdata;
    assign o_rvalid = s.rvalid;

    // --------------------------------------------------------------
    // assertions
    // --------------------------------------------------------------
    default clocking cb @(posedge i_mclk); endclocking
    default disable iff (!i_rst_n);

    logic ctrl_wr;
    assign ctrl_wr = i_req.wr && (i_req.addr == ADDR_RECEIVER_GEN_CTRL);

    AST_CKS_METHOD: assert property (
        $past(i_rst_n) |-> o_computed_checksum_store[1] ==
            ($past(s.ctrl[POS_CHECKSUM_MODE]) ? $past(sum_packed[1])
                                               : $past(sum_fields[1])))
        else $error("link 1 checksum does not follow method bit");
    AST_CKS_FIELDS: assert property (
        !s.ctrl[POS_CHECKSUM_MODE] ##1 $past(i_rst_n)
            |-> o_computed_checksum_store[0] == $past(sum_fields[0]))
        else $error("field checksum wrong");
    AST_CKS_PACKED: assert property (
        s.ctrl[POS_CHECKSUM_MODE] ##1 $past(i_rst_n)
            |-> o_computed_checksum_store[0] == $past(sum_packed[0]))
        else $error("packed checksum wrong");
    AST_LINK_MODE: assert property (
        ctrl_wr |=> o_dual_link == $past(i_req.wdata[POS_LINK_MODE]))
        else $error("link mode not taken from write");
    AST_PAGE_READ: assert property (
        i_req.rd && i_req.addr == ADDR_CHECKSUM_STORE && !i_req.wr
            |=> o_rvalid && o_rdata == ($past(o_page_link1)
                ? $past(o_computed_checksum_store[1])
                : $past(o_computed_checksum_store[0])))
        else $error("paged read returned wrong link");
    AST_LINK_EN: assert property (
        ctrl_wr |=> o_link_active == $past(i_req.wdata[1:0]))
        else $error("link enable not applied");
    AST_LINK_SINGLE: assert property (
        ctrl_wr && i_req.wdata[1:0] == 2'b01
            |=> o_link_active[0] && !o_link_active[1])
        else $error("0b01 must start only link 0");
    AST_LINK_BOTH: assert property (
        ctrl_wr && i_req.wdata[1:0] == 2'b11 |=> o_link_active == 2'b11)
        else $error("0b11 must start both links");
    AST_RSVD_ZERO: assert property (
        i_req.rd && !i_req.wr && i_req.addr == ADDR_RECEIVER_GEN_CTRL
            |=> (o_rdata & ~CTRL_WRITE_MASK) == 8'h00)
        else $error("reserved control bits read nonzero");
    AST_STABLE_CTRL: assert property (
        !ctrl_wr |=> $stable(o_link_active))
        else $error("link enable changed without a write");
    AST_LINK_ONE: assert property (
        ctrl_wr && i_req.wdata[1:0] == 2'b10
            |=> !o_link_active[0] && o_link_active[1])
        else $error("0b10 must start only link 1");
    AST_LINK_OFF: assert property (
        ctrl_wr && i_req.wdata[1:0] == 2'b00 |=> o_link_active == 2'b00)
        else $error("zero enable must stop both links");
    AST_TUNE_A_WR: assert property (
        i_req.wr && i_req.addr == ADDR_TERMINATION_TUNE_A
            |=> o_termination_tune_a == $past(i_req.wdata))
        else $error("termination tune A write lost");
    AST_TUNE_B_WR: assert property (
        i_req.wr && i_req.addr == ADDR_TERMINATION_TUNE_B
            |=> o_termination_tune_b == $past(i_req.wdata))
        else $error("termination tune B write lost");

    COV_BOTH_LINKS: cover property (o_link_active == 2'b11);
    COV_PACKED_MODE: cover property (
        ctrl_wr && i_req.wdata[POS_CHECKSUM_MODE] ##3 o_rvalid);
    COV_PAGE1_READ: cover property (
        o_page_link1 && i_req.rd && i_req.addr == ADDR_CHECKSUM_STORE);
    COV_TUNE_A: cover property (
        i_req.wr && i_req.addr == ADDR_TERMINATION_TUNE_A
            && i_req.wdata == 8'hb7);
endmodule

// File: tb/host_model.sv
// Purpose: host model driving the register port
// Assumes: requests launched 1 ns after the rising edge
// Notes:   idle address and data show the inverse of the last value
`timescale 1ns/1ps
module host_model (
    // clock
    input  wire logic                  i_mclk,
    // register port
    output rx_ctrl_pkg::reg_req_t      o_req,
    input  wire logic [7:0]            i_rdata,
    input  wire logic                  i_rvalid
);
    import rx_ctrl_pkg::*;
    // ----------------------------------------
    // bus cycles
    // ----------------------------------------
    initial o_req = '0;
    // one-cycle strobe, then release with scrambled lines
    task automatic wr(input logic [11:0] a, input logic [7:0] d);
        @(posedge i_mclk);
        #1 o_req = '{1'b1, 1'b0, a, d};
        @(posedge i_mclk);
        #1 o_req = '{1'b0, 1'b0, ~a, ~d};
    endtask
    // answer lives one cycle only, so take it right after its edge
    task automatic rd(input logic [11:0] a, output logic [7:0] d);
        @(posedge i_mclk);
        #1 o_req = '{1'b0, 1'b1, a, ~o_req.wdata};
        @(posedge i_mclk);
        #1 o_req = '{1'b0, 1'b0, ~a, ~o_req.wdata};
        d = i_rvalid ? i_rdata : 8'hxx;
    endtask
    // termination first, link enable last
    task automatic bring_up(input logic [7:0] ctrl);
        wr(ADDR_TERMINATION_TUNE_A, 8'hb7);
        wr(ADDR_TERMINATION_TUNE_B, 8'h87);
        wr(ADDR_RECEIVER_GEN_CTRL, ctrl);
    endtask
endmodule

// File: tb/serial_rx_link_general_control_tb.sv
// Purpose: self-checking bench for the receiver general control bank
// Assumes: host model owns the register port
// Notes:   expected checksums are recomputed from the link bytes
`timescale 1ns/1ps
module serial_rx_link_general_control_tb;
    import rx_ctrl_pkg::*;
    typedef struct packed {
        logic [7:0] wdata;
        logic [7:0] rdback;
    } row_t;
    // ----------------------------------------
    // stimulus table and signals
    // ----------------------------------------
    localparam row_t ROWS [8] = '{'{8'h00, 8'h00}, '{8'h01, 8'h01},
        '{8'h02, 8'h02}, '{8'h03, 8'h03}, '{8'h08, 8'h08},
        '{8'h04, 8'h04}, '{8'hff, 8'h4f}, '{8'hb0, 8'h00}};
    logic        i_mclk = 1'b0;
    logic        i_rst_n = 1'b0;
    reg_req_t    req;
    cfg_bytes_t  cfg [2];
    logic [7:0]  rdata, tune_a, tune_b, v, rb;
    logic        rvalid, dual, page;
    logic [1:0]  act;
    link_bytes_t cks;
    int          error_cnt = 0;
    int          checks_done = 0;

    always #20 i_mclk = ~i_mclk;

    rx_general_control i_dut (.i_mclk(i_mclk), .i_rst_n(i_rst_n),
        .i_req(req), .o_rdata(rdata), .o_rvalid(rvalid),
        .i_link_cfg(cfg), .o_link_active(act), .o_dual_link(dual),
        .o_page_link1(page), .o_computed_checksum_store(cks),
        .o_termination_tune_a(tune_a), .o_termination_tune_b(tune_b));
    host_model i_host (.i_mclk(i_mclk), .o_req(req), .i_rdata(rdata),
        .i_rvalid(rvalid));

    // ----------------------------------------
    // helpers
    // ----------------------------------------
    task automatic chk(input string n, input logic [7:0] s, e);
        checks_done++;
        if (s !== e) begin
            error_cnt++;
            $display("[FAIL] %s expected %h seen %h", n, e, s);
        end
    endtask
    // field sum leaves bytes 11 and 12 out
    function automatic logic [7:0] exp_cks(input cfg_bytes_t b, input logic m);
        logic [7:0] s;
        s = 8'h00;
        if (m) begin
            for (int i = 0; i < NUM_CFG_BYTES; i++)
                s = s + b[i];
        end else begin
            s = b[0] + 8'(b[1][3:0]) + 8'(b[1][7:4]) + 8'(b[2][4:0])
                + 8'(b[2][5]) + 8'(b[2][6]) + 8'(b[3][4:0]) + 8'(b[3][7])
                + b[4] + 8'(b[5][4:0]) + b[6] + 8'(b[7][4:0])
                + 8'(b[7][7:6]) + 8'(b[8][4:0]) + 8'(b[8][7:5])
                + 8'(b[9][4:0]) + 8'(b[9][7:5]) + 8'(b[10][4:0])
                + 8'(b[10][7]);
        end
        return s;
    endfunction
    task automatic final_report;
        if (error_cnt == 0 && checks_done > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    // watchdog cuts a hang short
    initial begin
        repeat (5000) @(posedge i_mclk);
        error_cnt++;
        final_report();
    end

    // ----------------------------------------
    // main sequence
    // ----------------------------------------
    initial begin
        for (int i = 0; i < NUM_CFG_BYTES; i++) begin
            cfg[0][i] = 8'(i * 37 + 5);
            cfg[1][i] = 8'(i * 91 + 200);
        end
        repeat (4) @(posedge i_mclk);
        #1 i_rst_n = 1'b1;
        chk("tune_a", tune_a, 8'hc3);
        chk("tune_b", tune_b, 8'h93);
        foreach (ROWS[k]) begin
            cfg[1][0] = ROWS[k].wdata;
            rb = ROWS[k].rdback;
            i_host.wr(ADDR_RECEIVER_GEN_CTRL, ROWS[k].wdata);
            chk("active", {6'h00, act}, {6'h00, rb[1:0]});
            chk("dual", {7'h00, dual}, {7'h00, rb[3]});
            chk("page", {7'h00, page}, {7'h00, rb[2]});
            i_host.rd(ADDR_RECEIVER_GEN_CTRL, v);
            chk("ctrl", v, rb);
            chk("cks0", cks[0], exp_cks(cfg[0], rb[6]));
            chk("cks1", cks[1], exp_cks(cfg[1], rb[6]));
            i_host.rd(ADDR_CHECKSUM_STORE, v);
            chk("paged", v, exp_cks(cfg[rb[2]], rb[6]));
        end
        // termination values written; tune A reads back, tune B is checked at its output
        i_host.bring_up(8'h4b);
        i_host.rd(ADDR_TERMINATION_TUNE_A, v);
        chk("tune_a", v, 8'hb7);
        chk("tune_b", tune_b, 8'h87);
        // unmapped and read-only places
        i_host.wr(12'h123, 8'h5a);
        i_host.rd(12'h123, v);
        chk("unmapped", v, 8'h00);
        i_host.wr(ADDR_CHECKSUM_STORE, 8'h00);
        chk("ro cks", cks[0], exp_cks(cfg[0], 1'b1));
        i_host.rd(ADDR_CHECKSUM_STORE, v);
        chk("ro cks rd", v, exp_cks(cfg[0], 1'b1));
        // reset in mid-run
        @(posedge i_mclk);
        #1 i_rst_n = 1'b0;
        @(posedge i_mclk);
        #1 i_rst_n = 1'b1;
        chk("rst tune_a", tune_a, 8'hc3);
        chk("rst active", {6'h00, act}, 8'h00);
        chk("rst cks", cks[0], 8'h00);
        final_report();
    end
endmodule
